// file: include/usf_pkg.sv
// constants and carrier types for the serial status-flag block
// assumes one bus clock and a byte-wide register port with a 3-bit address
package usf_pkg;
	// register offsets
	localparam logic [2:0] ADDR_CTRL1   = 3'h2;
	localparam logic [2:0] ADDR_CTRL2   = 3'h3;
	localparam logic [2:0] ADDR_STATUS  = 3'h4;
	localparam logic [2:0] ADDR_DATA_HI = 3'h6;
	localparam logic [2:0] ADDR_DATA_LO = 3'h7;
	// control field positions
	localparam int CTRL1_MODE9_BIT  = 4;
	localparam int CTRL1_PAR_EN_BIT = 1;
	localparam int CTRL1_PAR_TY_BIT = 0;
	localparam int CTRL2_RIE_BIT    = 5;
	localparam int CTRL2_STBY_BIT   = 1;
	// data high field positions
	localparam int DATA_HI_R8_BIT = 7;
	localparam int DATA_HI_T8_BIT = 6;
	// idle thresholds in bit times
	localparam logic [3:0] IDLE_ONES_8 = 4'ha;
	localparam logic [3:0] IDLE_ONES_9 = 4'hb;
	// reset values
	localparam logic [7:0] FLAGS_RESET = 8'hc0;
	localparam logic [8:0] DATA_RESET  = 9'h000;

	// status flags, msb first as they sit in the status register
	typedef struct packed {
		logic tx_buffer_empty_flag;
		logic tx_complete_flag;
		logic rx_buffer_full_flag;
		logic rx_idle_flag;
		logic rx_overrun_flag;
		logic rx_noise_flag;
		logic stop_bit_error_flag;
		logic parity_mismatch_flag;
	} usf_flags_type;

	// one finished frame from the receive shifter
	typedef struct packed {
		logic       done;
		logic       noise;
		logic       stop_bit;
		logic [8:0] data;
	} usf_rx_frame_type;

	// whole state of the block
	typedef struct packed {
		usf_flags_type flags;
		usf_flags_type armed_clr;
		logic          idle_armed;
		logic [3:0]    ones_cnt;
		logic [8:0]    rx_data;
		logic [8:0]    tx_data;
		logic          tx_write;
		logic          mode9;
		logic          parity_enable_bit;
		logic          parity_type_bit;
		logic          rx_standby_bit;
		logic          rx_full_irq_enable;
		logic [7:0]    rd_data;
	} usf_state_type;
endpackage

// file: hdl/usf_status.sv
// status-flag logic of an asynchronous serial transceiver
// assumes the shifters and baud logic sit outside and report events as one-cycle pulses
//
// Contract
// R01: a flag clears only after a status read, then a data register access; tx-complete here also clears while TX_QUEUE or TX_BUSY is high
// R02: writes to the status register change no flag
// R03: tx-buffer-empty sets when the tx shifter takes the data register
// R04: tx-buffer-empty clears by status read with it set, then data-low write
// R05: tx-complete low while sending, high when buffer empty and nothing sent
// R06: tx-complete clears by status read then data-low write, or when queued
// R07: tx-complete set and clear together leaves it cleared
// R08: rx-buffer-full sets when a frame moves into the rx data register
// R09: rx-buffer-full clears by status read with it set, then data-low read
// R10: idle sets after 10 ones in 8-bit mode, 11 in 9-bit mode
// R11: after idle clears, a valid frame must set rx-full before idle again
// R12: idle line does not set idle flag while standby bit is set
// R13: idle clears by status read with it set, then data-low read
// R14: overrun sets when a second frame completes before the data read
// R15: on overrun the new frame is dropped and rx data kept
// R16: overrun clears by status read with it set, then data-low read
// R17: software does a dummy data-low read if overrun shows without rx-full
// R18: noise flag sets with rx-full, not on overrun
// R19: stop-bit error sets with rx-full on zero stop bit, not on overrun
// R20: while stop-bit error is set, further frames are not received
// R21: parity mismatch sets with rx-full when enabled, not on overrun
// R22: noise, stop-bit and parity flags clear by status read then data-low read
// R23: mode bit selects eight or nine data bits, one start and one stop
// R24: hardware clears the standby bit when the receiver wakes
// R25: rx interrupt enable gates both rx-full and overrun requests
// R26: a status read latches set flags; only those clear on the later access
`timescale 1ns/100ps
`default_nettype none

module usf_status (
	input  wire logic                      SYS_CLK,
	input  wire logic                      RST_B,
	input  wire logic [2:0]                REG_ADDR,
	input  wire logic [7:0]                REG_WDATA,
	input  wire logic                      REG_WR,
	input  wire logic                      REG_RD,
	output logic [7:0]                     REG_RDATA,
	input  wire logic                      TX_LOAD,
	input  wire logic                      TX_BUSY,
	input  wire logic                      TX_QUEUE,
	output logic [8:0]                     TX_DATA,
	output logic                           TX_WRITE,
	input  wire usf_pkg::usf_rx_frame_type RX_FRAME,
	input  wire logic                      RX_BIT_STB,
	input  wire logic                      RX_BIT_VAL,
	input  wire logic                      RX_WAKE,
	output logic                           RX_MODE9,
	output logic                           RX_STANDBY,
	output logic                           RX_IRQ
);

	usf_pkg::usf_state_type state_reg;
	usf_pkg::usf_state_type state_next;

	// decoded bus accesses, frame qualification, idle limit, flag clear and set masks
	logic                   rd_status;
	logic                   rd_data_lo;
	logic                   wr_data_lo;
	logic                   frame_ok;
	logic                   frame_ovr;
	logic                   par_bad;
	logic [3:0]             idle_limit;
	usf_pkg::usf_flags_type clr_rx;
	usf_pkg::usf_flags_type clr_tx;
	usf_pkg::usf_flags_type set_f;

	////////////////////////////////////////////////////////////////////////
	// access decode and frame qualification
	assign rd_status  = REG_RD && (REG_ADDR == usf_pkg::ADDR_STATUS);
	assign rd_data_lo = REG_RD && (REG_ADDR == usf_pkg::ADDR_DATA_LO);
	assign wr_data_lo = REG_WR && (REG_ADDR == usf_pkg::ADDR_DATA_LO);
	// frames are refused while a stop-bit error stands
	assign frame_ok   = RX_FRAME.done && !state_reg.flags.stop_bit_error_flag; // R20
	assign frame_ovr  = frame_ok && state_reg.flags.rx_buffer_full_flag; // R14
	// parity over all data bits, parity bit included
	assign par_bad    = state_reg.parity_enable_bit
		&& ((^(state_reg.mode9 ? RX_FRAME.data : {1'b0, RX_FRAME.data[7:0]}))
		!= state_reg.parity_type_bit); // R21
	assign idle_limit = state_reg.mode9 ? usf_pkg::IDLE_ONES_9 : usf_pkg::IDLE_ONES_8; // R10 R23

	////////////////////////////////////////////////////////////////////////
	// clear masks: only flags latched at the last status read
	always_comb begin
		clr_rx = '0;
		clr_tx = '0;
		if (rd_data_lo) begin
			clr_rx = state_reg.armed_clr; // R01 R26
			clr_rx.tx_buffer_empty_flag = 1'b0;
			clr_rx.tx_complete_flag     = 1'b0;
		end
		if (wr_data_lo) begin
			clr_tx.tx_buffer_empty_flag = state_reg.armed_clr.tx_buffer_empty_flag; // R04
			clr_tx.tx_complete_flag     = state_reg.armed_clr.tx_complete_flag; // R06
		end
	end

	////////////////////////////////////////////////////////////////////////
	// set events
	always_comb begin
		set_f = '0;
		set_f.tx_buffer_empty_flag = TX_LOAD; // R03
		set_f.tx_complete_flag     = state_reg.flags.tx_buffer_empty_flag && !TX_BUSY; // R05
		set_f.rx_buffer_full_flag  = frame_ok && !frame_ovr; // R08
		set_f.rx_overrun_flag      = frame_ovr; // R14
		set_f.rx_noise_flag        = frame_ok && !frame_ovr && RX_FRAME.noise; // R18
		set_f.stop_bit_error_flag  = frame_ok && !frame_ovr && !RX_FRAME.stop_bit; // R19
		set_f.parity_mismatch_flag = frame_ok && !frame_ovr && par_bad; // R21
		// idle flag only when armed by a frame and not in standby
		set_f.rx_idle_flag = RX_BIT_STB && RX_BIT_VAL
			&& (state_reg.ones_cnt == idle_limit - 4'h1)
			&& state_reg.idle_armed && !state_reg.rx_standby_bit; // R10 R11 R12
	end

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		state_next          = state_reg;
		state_next.tx_write = 1'b0;
		// set wins over clear, except tx-complete where clear wins
		state_next.flags = (state_reg.flags & ~(clr_rx | clr_tx)) | set_f; // R01 R09 R13 R16 R22
		state_next.flags.tx_complete_flag = (state_reg.flags.tx_complete_flag
			|| set_f.tx_complete_flag) && !clr_tx.tx_complete_flag
			&& !TX_QUEUE && !TX_BUSY; // R05 R06 R07
		// consumed latch bits are dropped
		state_next.armed_clr = state_reg.armed_clr & ~(clr_rx | clr_tx);
		if (rd_status) begin
			state_next.armed_clr = state_reg.flags; // R26
		end
		// consecutive ones on the receive line
		if (RX_BIT_STB) begin
			if (!RX_BIT_VAL) begin
				state_next.ones_cnt = 4'h0;
			end else if (state_reg.ones_cnt != 4'hf) begin
				state_next.ones_cnt = state_reg.ones_cnt + 4'h1;
			end
		end
		// idle arming
		if (set_f.rx_buffer_full_flag) begin
			state_next.idle_armed = 1'b1; // R11
		end else if (set_f.rx_idle_flag || clr_rx.rx_idle_flag) begin
			state_next.idle_armed = 1'b0; // R11
		end
		// received data, kept on overrun or error block
		if (set_f.rx_buffer_full_flag) begin
			state_next.rx_data = RX_FRAME.data; // R08 R15
		end
		// register writes; status writes fall through untouched
		if (REG_WR) begin
			case (REG_ADDR)
				usf_pkg::ADDR_CTRL1: begin
					state_next.mode9             = REG_WDATA[usf_pkg::CTRL1_MODE9_BIT]; // R23
					state_next.parity_enable_bit = REG_WDATA[usf_pkg::CTRL1_PAR_EN_BIT];
					state_next.parity_type_bit   = REG_WDATA[usf_pkg::CTRL1_PAR_TY_BIT];
				end
				usf_pkg::ADDR_CTRL2: begin
					state_next.rx_full_irq_enable = REG_WDATA[usf_pkg::CTRL2_RIE_BIT];
					state_next.rx_standby_bit     = REG_WDATA[usf_pkg::CTRL2_STBY_BIT];
				end
				usf_pkg::ADDR_DATA_HI: begin
					state_next.tx_data[8] = REG_WDATA[usf_pkg::DATA_HI_T8_BIT];
				end
				usf_pkg::ADDR_DATA_LO: begin
					state_next.tx_data[7:0] = REG_WDATA;
					state_next.tx_write     = 1'b1;
				end
				default: begin
				end
			endcase
		end
		// wakeup clears standby
		if (RX_WAKE) begin
			state_next.rx_standby_bit = 1'b0; // R24
		end
		// read data, valid the cycle after the strobe
		state_next.rd_data = 8'h00;
		if (REG_RD) begin
			case (REG_ADDR)
				usf_pkg::ADDR_CTRL1: begin
					state_next.rd_data[usf_pkg::CTRL1_MODE9_BIT]  = state_reg.mode9;
					state_next.rd_data[usf_pkg::CTRL1_PAR_EN_BIT] = state_reg.parity_enable_bit;
					state_next.rd_data[usf_pkg::CTRL1_PAR_TY_BIT] = state_reg.parity_type_bit;
				end
				usf_pkg::ADDR_CTRL2: begin
					state_next.rd_data[usf_pkg::CTRL2_RIE_BIT]  = state_reg.rx_full_irq_enable;
					state_next.rd_data[usf_pkg::CTRL2_STBY_BIT] = state_reg.rx_standby_bit;
				end
				usf_pkg::ADDR_STATUS: begin
					state_next.rd_data = state_reg.flags;
				end
				usf_pkg::ADDR_DATA_HI: begin
					state_next.rd_data[usf_pkg::DATA_HI_R8_BIT] = state_reg.rx_data[8];
					state_next.rd_data[usf_pkg::DATA_HI_T8_BIT] = state_reg.tx_data[8];
				end
				usf_pkg::ADDR_DATA_LO: begin
					state_next.rd_data = state_reg.rx_data[7:0];
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			state_reg       <= '0;
			state_reg.flags <= usf_pkg::FLAGS_RESET;
			state_reg.rx_data <= usf_pkg::DATA_RESET;
			state_reg.tx_data <= usf_pkg::DATA_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign REG_RDATA  = state_reg.rd_data;
	assign TX_DATA    = state_reg.tx_data;
	assign TX_WRITE   = state_reg.tx_write;
	assign RX_MODE9   = state_reg.mode9;
	assign RX_STANDBY = state_reg.rx_standby_bit;
	// rx request, muted in standby
	assign RX_IRQ = state_reg.rx_full_irq_enable && !state_reg.rx_standby_bit
		&& (state_reg.flags.rx_buffer_full_flag || state_reg.flags.rx_overrun_flag); // R25

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);

	a_status_write_ignored: assert property ( // R02
		(REG_WR && REG_ADDR == usf_pkg::ADDR_STATUS && !TX_LOAD && !RX_FRAME.done && !RX_BIT_STB
		&& !REG_RD)
		|=> (state_reg.flags[7] == $past(state_reg.flags[7])) && (state_reg.flags[5:0] == $past(state_reg.flags[5:0])))
		else $error("status write changed a flag");

	a_tx_buffer_empty_flag_load_set: assert property ( // R03
		TX_LOAD |=> state_reg.flags.tx_buffer_empty_flag)
		else $error("buffer empty not set after load");

	a_tc_queue_clear: assert property ( // R06 R07
		(TX_QUEUE || TX_BUSY) |=> !state_reg.flags.tx_complete_flag)
		else $error("tx complete high while queued or busy");

	a_rx_buffer_full_flag_clear_seq: assert property ( // R09
		(rd_data_lo && state_reg.armed_clr.rx_buffer_full_flag && !RX_FRAME.done)
		|=> !state_reg.flags.rx_buffer_full_flag)
		else $error("rx full not cleared by sequence");

	a_ovr_data_kept: assert property ( // R14 R15
		(RX_FRAME.done && state_reg.flags.rx_buffer_full_flag && !state_reg.flags.stop_bit_error_flag)
		|=> state_reg.flags.rx_overrun_flag && $stable(state_reg.rx_data))
		else $error("overrun mishandled");

	a_tx_buffer_empty_flag_write_clear: assert property ( // R04
		(wr_data_lo && state_reg.armed_clr.tx_buffer_empty_flag && !TX_LOAD)
		|=> !state_reg.flags.tx_buffer_empty_flag)
		else $error("buffer empty not cleared by sequence");

	a_tc_write_clear: assert property ( // R06 R07
		(wr_data_lo && state_reg.armed_clr.tx_complete_flag) |=> !state_reg.flags.tx_complete_flag)
		else $error("tx complete not cleared by sequence");

	a_tc_idle_set: assert property ( // R05
		(state_reg.flags.tx_buffer_empty_flag && !TX_BUSY && !TX_QUEUE
		&& !(wr_data_lo && state_reg.armed_clr.tx_complete_flag)) |=> state_reg.flags.tx_complete_flag)
		else $error("tx complete not set when idle");

	a_rx_buffer_full_flag_frame_set: assert property ( // R08
		(RX_FRAME.done && !state_reg.flags.rx_buffer_full_flag && !state_reg.flags.stop_bit_error_flag)
		|=> state_reg.flags.rx_buffer_full_flag && (state_reg.rx_data == $past(RX_FRAME.data)))
		else $error("frame not stored");

	a_ovr_no_noise: assert property ( // R18
		(RX_FRAME.done && state_reg.flags.rx_buffer_full_flag && !state_reg.flags.rx_noise_flag)
		|=> !state_reg.flags.rx_noise_flag)
		else $error("noise set on overrun");

	a_err_read_clear: assert property ( // R16 R22
		(rd_data_lo && state_reg.armed_clr.rx_overrun_flag && state_reg.armed_clr.stop_bit_error_flag)
		|=> !state_reg.flags.rx_overrun_flag && !state_reg.flags.stop_bit_error_flag)
		else $error("error flags not cleared by sequence");

	a_idle_count_set: assert property ( // R10
		(RX_BIT_STB && RX_BIT_VAL && (state_reg.ones_cnt == idle_limit - 4'h1)
		&& state_reg.idle_armed && !state_reg.rx_standby_bit) |=> state_reg.flags.rx_idle_flag)
		else $error("idle not set after ones");

	a_data_rdata: assert property ( // R09
		rd_data_lo |=> REG_RDATA == $past(state_reg.rx_data[7:0]))
		else $error("data read wrong");

	a_fe_blocks_rx: assert property ( // R20
		(RX_FRAME.done && state_reg.flags.stop_bit_error_flag) |=> $stable(state_reg.rx_data))
		else $error("frame taken during stop-bit error");

	a_idle_standby: assert property ( // R12
		(state_reg.rx_standby_bit && !state_reg.flags.rx_idle_flag) |=> !state_reg.flags.rx_idle_flag)
		else $error("idle set in standby");

	a_irq_gate: assert property ( // R25
		!state_reg.rx_full_irq_enable |-> !RX_IRQ)
		else $error("irq without enable");

	a_status_rdata: assert property ( // R26
		rd_status |=> REG_RDATA == $past(state_reg.flags))
		else $error("status read data wrong");

	a_wake_clears: assert property ( // R24
		RX_WAKE |=> !RX_STANDBY)
		else $error("standby not cleared on wake");

endmodule

`default_nettype wire

// file: dv/usf_far_model.sv
// far side of the status block: transmit shifter and receive shifter events
// assumes the status block samples every input on the rising bus clock
`timescale 1ns/100ps
`default_nettype none

module usf_far_model (
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	input  wire logic                     tx_write,
	output var logic                      tx_queue,
	output var logic                      tx_load,
	output logic                          tx_busy,
	output var usf_pkg::usf_rx_frame_type rx_frame,
	output var logic                      rx_bit_stb,
	output var logic                      rx_bit_val,
	output var logic                      rx_wake
);
	logic [3:0] dly_reg;
	logic [4:0] busy_reg;

	////////////////////////////////////////////////////////////////////////////////
	// queue at once, shifter takes the data 8 cycles later, sends 16 cycles
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dly_reg  <= 4'h0;
			busy_reg <= 5'h00;
			tx_queue <= 1'h0;
			tx_load  <= 1'h0;
		end else begin
			tx_queue <= tx_write;
			tx_load  <= (dly_reg == 4'h1);
			dly_reg  <= tx_write ? 4'h8 : (dly_reg != 4'h0) ? dly_reg - 4'h1 : 4'h0;
			busy_reg <= (dly_reg == 4'h1) ? 5'h10 : (busy_reg != 5'h00) ? busy_reg - 5'h01 : 5'h00;
		end
	end
	assign tx_busy = (busy_reg != 5'h00) | tx_load;

	////////////////////////////////////////////////////////////////////////////////
	// receive side idles with no events
	initial begin
		rx_frame   = '0;
		rx_bit_stb = 1'h0;
		rx_bit_val = 1'h0;
		rx_wake    = 1'h0;
	end

	// one finished frame; fields scrambled once done drops
	task automatic frame(input logic [8:0] d, input logic nz, input logic sb);
		@(posedge clk);
		rx_frame <= {1'h1, nz, sb, d};
		@(posedge clk);
		rx_frame <= {1'h0, ~nz, ~sb, ~d};
	endtask

	// n bit times of one level on the line
	task automatic bits(input int n, input logic v);
		repeat (n) begin
			@(posedge clk);
			rx_bit_stb <= 1'h1;
			rx_bit_val <= v;
			@(posedge clk);
			rx_bit_stb <= 1'h0;
			rx_bit_val <= ~v;
		end
	endtask

	// receiver wakes from standby
	task automatic wake;
		@(posedge clk);
		rx_wake <= 1'h1;
		@(posedge clk);
		rx_wake <= 1'h0;
	endtask
endmodule

`default_nettype wire

// file: dv/tb.sv
// self-checking bench for the serial status-flag block
// assumes the far-side model in usf_far_model and a 125 MHz bus clock
`timescale 1ns/100ps
`default_nettype none

module tb;
	logic                      sys_clk   = 1'h0;
	logic                      rst_b     = 1'h0;
	logic [2:0]                reg_addr  = 3'h0;
	logic [7:0]                reg_wdata = 8'h00;
	logic                      reg_wr    = 1'h0;
	logic                      reg_rd    = 1'h0;
	logic [7:0]                reg_rdata;
	logic [7:0]                got;
	logic [8:0]                tx_data;
	logic                      tx_load, tx_busy, tx_queue, tx_write, rx_wake;
	logic                      rx_bit_stb, rx_bit_val, rx_mode9, rx_standby, rx_irq;
	usf_pkg::usf_rx_frame_type rx_frame;
	int                        n_mismatch  = 0;
	int                        comparisons = 0;
	int                        cycles      = 0;

	usf_status i_dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .TX_LOAD(tx_load), .TX_BUSY(tx_busy),
		.TX_QUEUE(tx_queue), .TX_DATA(tx_data), .TX_WRITE(tx_write), .RX_FRAME(rx_frame),
		.RX_BIT_STB(rx_bit_stb), .RX_BIT_VAL(rx_bit_val), .RX_WAKE(rx_wake), .RX_MODE9(rx_mode9),
		.RX_STANDBY(rx_standby), .RX_IRQ(rx_irq));
	usf_far_model i_far (.clk(sys_clk), .rst_b(rst_b), .tx_write(tx_write), .tx_queue(tx_queue),
		.tx_load(tx_load), .tx_busy(tx_busy), .rx_frame(rx_frame), .rx_bit_stb(rx_bit_stb),
		.rx_bit_val(rx_bit_val), .rx_wake(rx_wake));

	////////////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: run hung", $time);
			complete_run;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// compare, bus cycles, verdict
	task automatic chk(input logic [8:0] g, input logic [8:0] e);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'h1;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
		#1;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] q);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'h1;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		#1;
		q = reg_rdata;
	endtask
	task automatic sts(input logic [7:0] e);
		rd(usf_pkg::ADDR_STATUS, got);
		chk(got, e);
	endtask
	task automatic rdl(input logic [7:0] e);
		rd(usf_pkg::ADDR_DATA_LO, got);
		chk(got, e);
	endtask
	task automatic complete_run;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'h1;
		sts(usf_pkg::FLAGS_RESET);
		wr(usf_pkg::ADDR_STATUS, 8'h00);
		sts(8'hc0);
		rd(3'h0, got);
		chk(got, 8'h00);
		// transmit: clear by status read then data write, set on load
		wr(usf_pkg::ADDR_DATA_LO, 8'h55);
		chk({tx_write, tx_data[7:0]}, 9'h155);
		sts(8'h00);
		repeat (8) @(posedge sys_clk);
		sts(8'h80);
		repeat (30) @(posedge sys_clk);
		sts(8'hc0);
		// receive: data read alone clears nothing
		i_far.frame(9'h03c, 1'h0, 1'h1);
		rdl(8'h3c);
		sts(8'he0);
		rdl(8'h3c);
		sts(8'hc0);
		// overrun after the status read
		i_far.frame(9'h011, 1'h0, 1'h1);
		sts(8'he0);
		i_far.frame(9'h022, 1'h1, 1'h0);
		rdl(8'h11);
		sts(8'hc8);
		rdl(8'h11);
		sts(8'hc0);
		// noise, zero stop bit, parity mismatch; next frame blocked
		wr(usf_pkg::ADDR_CTRL1, 8'h02);
		i_far.frame(9'h107, 1'h1, 1'h0);
		i_far.frame(9'h044, 1'h0, 1'h1);
		sts(8'he7);
		rdl(8'h07);
		sts(8'hc0);
		// idle after 10 ones, not again until a frame
		wr(usf_pkg::ADDR_CTRL1, 8'h00);
		i_far.bits(9, 1'h1);
		sts(8'hc0);
		i_far.bits(1, 1'h1);
		sts(8'hd0);
		rdl(8'h07);
		sts(8'hc0);
		i_far.bits(12, 1'h1);
		sts(8'hc0);
		// standby holds idle off; wake clears standby
		wr(usf_pkg::ADDR_CTRL2, 8'h02);
		i_far.frame(9'h0aa, 1'h0, 1'h1);
		i_far.bits(1, 1'h0);
		i_far.bits(12, 1'h1);
		sts(8'he0);
		chk(rx_standby, 1'h1);
		i_far.wake;
		repeat (2) @(posedge sys_clk);
		chk(rx_standby, 1'h0);
		// nine-bit mode needs 11 ones
		wr(usf_pkg::ADDR_CTRL1, 8'h10);
		i_far.bits(1, 1'h0);
		i_far.bits(10, 1'h1);
		chk(rx_mode9, 1'h1);
		sts(8'he0);
		i_far.bits(1, 1'h1);
		sts(8'hf0);
		// receive request gated by its enable
		wr(usf_pkg::ADDR_CTRL2, 8'h20);
		@(posedge sys_clk);
		chk(rx_irq, 1'h1);
		wr(usf_pkg::ADDR_CTRL2, 8'h00);
		@(posedge sys_clk);
		chk(rx_irq, 1'h0);
		complete_run;
	end
endmodule

`default_nettype wire
